/* hdl/dus_pkg.sv */
// Package: constants and types for the digitizer unload and sequencing block
package dus_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_HZ = 20_000_000;
   localparam int SELFTEST_TRIG_S = 1;
   localparam int SELFTEST_HOLD_S = 2;
   localparam int SELFTEST_TRIG_CYC = SELFTEST_TRIG_S * CLK_HZ;
   localparam int SELFTEST_HOLD_CYC = SELFTEST_HOLD_S * CLK_HZ;
   localparam int SCAN_STEP_US = 5;
   localparam int SCAN_STEP_CYC = (SCAN_STEP_US * CLK_HZ) / 1_000_000;
   localparam int RELOAD_US = 2;
   localparam int RELOAD_CYC = (RELOAD_US * CLK_HZ) / 1_000_000;
   localparam int MEM_WAIT_CYC = 4;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [11:0] ADDR_STATUS = 12'h000;
   localparam logic [11:0] ADDR_CONFIG = 12'h004;
   localparam logic [11:0] ADDR_UNLOAD = 12'h008;
   localparam logic [11:0] ADDR_DATA = 12'h00c;
   localparam logic [11:0] ADDR_OLDEST = 12'h010;
   localparam logic [11:0] ADDR_CMD = 12'h014;
   localparam logic [11:0] ADDR_MEMSIZE = 12'h018;
   // ==========================================================
   // Field positions
   localparam int CFG_CHAN_LSB = 0;   // [1:0] channel code
   localparam int CFG_EXTCLK_BIT = 2;
   localparam int CFG_RATE_LSB = 4;   // [7:4] rate code
   localparam int UNL_CHAN_LSB = 0;   // [4:0] channel index
   localparam int UNL_SAMPLE_LSB = 8; // [27:8] sample number
   localparam int CMD_TRIG_BIT = 0;
   localparam int CMD_SELFTEST_BIT = 1;
   localparam int CMD_ARM_BIT = 2;
   localparam int CMD_STOP_BIT = 3;
   // ==========================================================
   // Reset values
   localparam logic [1:0] CHAN_CODE_RST = 2'h3;
   localparam logic [3:0] RATE_RST = 4'h0;
   localparam logic [19:0] MEMSIZE_RST = 20'hfffff;
   localparam int NUM_RATES = 9;
   localparam int ADDR_W = 20;
   localparam int WORD_W = 16;

   typedef enum logic [1:0] {
      DUS_IDLE = 2'b00,
      DUS_FETCH = 2'b01,
      DUS_FULL = 2'b10,
      DUS_RELOAD = 2'b11
   } dus_unl_type;

   // Internal rate divider counts, 40k down to 0.1k
   function automatic logic [17:0] dus_rate_div(input logic [3:0] code);
      unique case (code)
         4'h0: dus_rate_div = 18'(CLK_HZ / 40_000);
         4'h1: dus_rate_div = 18'(CLK_HZ / 20_000);
         4'h2: dus_rate_div = 18'(CLK_HZ / 10_000);
         4'h3: dus_rate_div = 18'(CLK_HZ / 5_000);
         4'h4: dus_rate_div = 18'(CLK_HZ / 2_000);
         4'h5: dus_rate_div = 18'(CLK_HZ / 1_000);
         4'h6: dus_rate_div = 18'(CLK_HZ / 500);
         4'h7: dus_rate_div = 18'(CLK_HZ / 200);
         default: dus_rate_div = 18'(CLK_HZ / 100);
      endcase
   endfunction

   // Channel code to active count 4, 8, 16, 32
   function automatic logic [5:0] dus_chan_count(input logic [1:0] code);
      dus_chan_count = 6'h04 << code;
   endfunction
endpackage

/* hdl/dus_top.sv */
// Unload address engine, self-test sequencer, clock and trigger control
`timescale 1ns/1ps
`default_nettype none
module dus_top
   import dus_pkg::*;
#(
   parameter int SELFTEST_TRIG = SELFTEST_TRIG_CYC, // Self-test trigger delay
   parameter int SELFTEST_HOLD = SELFTEST_HOLD_CYC  // Self-test generator time
) (
   input wire logic pclk,                          // Bus clock
   input wire logic presetn,                       // Async reset, active low
   input wire logic psel,                          // APB select
   input wire logic penable,                       // APB enable
   input wire logic pwrite,                        // APB direction
   input wire logic [11:0] paddr,                  // APB address
   input wire logic [31:0] pwdata,                 // APB write data
   output logic [31:0] prdata,                     // APB read data
   output logic pready,                            // APB ready
   output logic pslverr,                           // APB error
   output logic q_resp,                            // Data request valid
   input wire logic [dus_pkg::ADDR_W-1:0] oldest_addr, // Oldest channel-zero addr
   input wire logic [dus_pkg::ADDR_W-1:0] mem_size_sw, // Board switch memory size
   output logic [dus_pkg::ADDR_W-1:0] mem_addr,    // External memory address
   output logic mem_rd,                            // External memory read strobe
   input wire logic [dus_pkg::WORD_W-1:0] mem_rdata, // External memory data
   input wire logic ext_clk_pin,                   // Front panel clock
   input wire logic ext_trig_pin,                  // Front panel trigger
   output logic sample_tick,                       // Selected sample clock pulse
   output logic event_trig,                        // Combined trigger pulse
   output logic selftest_sel,                      // Inputs on test generator
   output logic scan_busy                          // Digitizing scan running
);
   import dus_pkg::*;

   typedef struct packed {
      // APB response
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic q_resp;

      // Configuration
      logic [1:0] chan_code;
      logic ext_clk;
      logic [3:0] rate;

      // Unload engine
      logic [4:0] chan_req;
      logic [19:0] sample_no;
      dus_unl_type unl;
      logic unload_mode;
      logic [ADDR_W-1:0] addr;
      logic mem_rd;
      logic [WORD_W-1:0] buffer;
      logic [7:0] wait_cnt;

      // Arming and self test
      logic armed;
      logic [31:0] st_cnt;
      logic st_active;
      logic st_fired;

      // Pin synchronisers
      logic [1:0] clk_sync;
      logic clk_prev;
      logic [1:0] trig_sync;
      logic trig_prev;

      // Sample clock and scan timer
      logic [17:0] div_cnt;
      logic sample_tick;
      logic event_trig;
      logic [11:0] scan_cnt;
      logic scan_busy;
   } dus_state_type;

   dus_state_type cur;
   dus_state_type nxt;

   // Address arithmetic with wraparound
   function automatic logic [ADDR_W-1:0] wrap_add(input logic [ADDR_W-1:0] a,
                                                  input logic [ADDR_W+5:0] b,
                                                  input logic [ADDR_W-1:0] size);
      logic [ADDR_W+6:0] s;
      s = {7'h00, a} + {1'b0, b};
      if (size == '0) begin
         wrap_add = s[ADDR_W-1:0];
      end else begin
         wrap_add = ADDR_W'(s % {7'h00, size});
      end
   endfunction

   // ==========================================================
   // Next-state logic
   always_comb begin
      logic acc;
      logic wr;
      logic rd;
      logic [5:0] cnt;
      logic [ADDR_W+5:0] prod;
      logic [ADDR_W-1:0] start;
      logic clk_edge;
      logic trig_edge;
      logic st_trig;
      nxt = cur;
      acc = psel && penable && !cur.pready;
      wr = acc && pwrite;
      rd = acc && !pwrite;
      cnt = dus_chan_count(cur.chan_code);
      nxt.pready = acc;
      nxt.pslverr = 1'b0;
      nxt.mem_rd = 1'b0;
      nxt.sample_tick = 1'b0;
      nxt.event_trig = 1'b0;
      prod = '0;
      start = '0;
      st_trig = 1'b0;
      clk_edge = 1'b0;
      trig_edge = 1'b0;
      if (!acc) begin
         nxt.prdata = '0;
      end

      // ==========================================================
      // Pin synchronisers
      nxt.clk_sync = {cur.clk_sync[0], ext_clk_pin};
      nxt.trig_sync = {cur.trig_sync[0], ext_trig_pin};
      nxt.clk_prev = cur.clk_sync[1];
      nxt.trig_prev = cur.trig_sync[1];
      clk_edge = cur.clk_sync[1] && !cur.clk_prev;
      trig_edge = cur.trig_sync[1] && !cur.trig_prev;

      // ==========================================================
      // Internal rate divider
      if (cur.div_cnt >= dus_rate_div(cur.rate) - 18'h1) begin
         nxt.div_cnt = '0;
      end else begin
         nxt.div_cnt = cur.div_cnt + 18'h1;
      end
      if (cur.ext_clk) begin
         nxt.sample_tick = clk_edge;
      end else begin
         nxt.sample_tick = (cur.div_cnt == '0);
      end

      // ==========================================================
      // Scan timer: 5 us per channel plus 5 us
      if (cur.sample_tick && cur.armed && !cur.unload_mode) begin
         nxt.scan_busy = 1'b1;
         nxt.scan_cnt = 12'((int'(cnt) + 1) * SCAN_STEP_CYC);
      end else if (cur.scan_cnt != '0) begin
         nxt.scan_cnt = cur.scan_cnt - 12'h1;
         nxt.scan_busy = (cur.scan_cnt != 12'h1);
      end

      // ==========================================================
      // Self-test sequencer
      if (cur.st_active) begin
         nxt.st_cnt = cur.st_cnt + 32'h1;
         if (!cur.st_fired && cur.st_cnt == 32'(SELFTEST_TRIG - 1)) begin
            st_trig = 1'b1;
            nxt.st_fired = 1'b1;
         end
         if (cur.st_cnt == 32'(SELFTEST_HOLD - 1)) begin
            nxt.st_active = 1'b0;
         end
      end

      // ==========================================================
      // Unload buffer engine; register writes below override it
      unique case (cur.unl)
         DUS_IDLE: begin
         end
         DUS_FETCH, DUS_RELOAD: begin
            // Wait out the memory access time, then latch the word
            if (cur.wait_cnt == '0) begin
               nxt.buffer = mem_rdata;
               nxt.unl = DUS_FULL;
            end else begin
               nxt.wait_cnt = cur.wait_cnt - 8'h1;
            end
         end
         DUS_FULL: begin
            if (rd && paddr == ADDR_DATA) begin
               nxt.addr = wrap_add(cur.addr, 26'(cnt), mem_size_sw);
               nxt.mem_rd = 1'b1;
               nxt.wait_cnt = 8'(MEM_WAIT_CYC);
               nxt.unl = DUS_RELOAD;
            end
         end
      endcase

      // ==========================================================
      // Register writes
      if (wr) begin
         unique case (paddr)
            // Leaves unload mode and drops a fetch in flight
            ADDR_CONFIG: begin
               nxt.chan_code = pwdata[CFG_CHAN_LSB +: 2];
               nxt.ext_clk = pwdata[CFG_EXTCLK_BIT];
               if (pwdata[CFG_RATE_LSB +: 4] < 4'(NUM_RATES)) begin
                  nxt.rate = pwdata[CFG_RATE_LSB +: 4];
               end
               nxt.unload_mode = 1'b0;
               nxt.unl = DUS_IDLE;
            end
            // New start address, then a fresh first fetch
            ADDR_UNLOAD: begin
               nxt.chan_req = pwdata[UNL_CHAN_LSB +: 5];
               nxt.sample_no = pwdata[UNL_SAMPLE_LSB +: 20];
               prod = 26'(cnt) * 26'(pwdata[UNL_SAMPLE_LSB +: 20]);
               start = wrap_add(oldest_addr, prod, mem_size_sw);
               start = wrap_add(start, 26'(pwdata[UNL_CHAN_LSB +: 5]),
                                mem_size_sw);
               nxt.addr = start;
               nxt.unload_mode = 1'b1;
               nxt.unl = DUS_FETCH;
               nxt.mem_rd = 1'b1;
               nxt.wait_cnt = 8'(MEM_WAIT_CYC);
               nxt.q_resp = ({1'b0, pwdata[UNL_CHAN_LSB +: 5]} < cnt);
            end
            // Disarm wins over arm in one write
            ADDR_CMD: begin
               if (pwdata[CMD_ARM_BIT]) begin
                  nxt.armed = 1'b1;
               end
               if (pwdata[CMD_STOP_BIT]) begin
                  nxt.armed = 1'b0;
               end
               if (pwdata[CMD_TRIG_BIT] && cur.armed) begin
                  nxt.event_trig = 1'b1;
               end
               if (pwdata[CMD_SELFTEST_BIT]) begin
                  nxt.st_active = 1'b1;
                  nxt.st_fired = 1'b0;
                  nxt.st_cnt = '0;
               end
            end
            ADDR_STATUS, ADDR_DATA, ADDR_OLDEST, ADDR_MEMSIZE: begin
               nxt.pslverr = 1'b0;
            end
            default: begin
               nxt.pslverr = 1'b1;
            end
         endcase
      end

      // ==========================================================
      // Trigger OR: panel, command, self test alike
      if ((trig_edge || st_trig) && cur.armed) begin
         nxt.event_trig = 1'b1;
      end

      // ==========================================================
      // Register reads
      if (rd) begin
         unique case (paddr)
            ADDR_STATUS: begin
               nxt.prdata = {19'h0, cur.scan_busy, cur.st_active, cur.armed,
                             cur.unload_mode, cur.q_resp, 1'b0, cur.unl,
                             cur.unl == DUS_FULL, cur.chan_code, 2'b00};
            end
            ADDR_CONFIG: begin
               nxt.prdata = {24'h0, cur.rate, 1'b0, cur.ext_clk, cur.chan_code};
            end
            ADDR_UNLOAD: begin
               nxt.prdata = {4'h0, cur.sample_no, 3'h0, cur.chan_req};
            end
            ADDR_DATA: begin
               nxt.prdata = {16'h0, cur.buffer};
            end
            ADDR_OLDEST: begin
               nxt.prdata = {12'h0, oldest_addr};
            end
            ADDR_MEMSIZE: begin
               nxt.prdata = {12'h0, mem_size_sw};
            end
            ADDR_CMD: begin
               nxt.prdata = '0;
            end
            default: begin
               nxt.prdata = '0;
               nxt.pslverr = 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
         cur.chan_code <= CHAN_CODE_RST;
         cur.rate <= RATE_RST;
         cur.unl <= DUS_IDLE;
      end else begin
         cur <= nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = cur.pslverr;
   assign q_resp = cur.q_resp;
   assign mem_addr = cur.addr;
   assign mem_rd = cur.mem_rd;
   assign sample_tick = cur.sample_tick;
   assign event_trig = cur.event_trig;
   assign selftest_sel = cur.st_active;
   assign scan_busy = cur.scan_busy;
endmodule // dus_top
`default_nettype wire

/* dv/dus_checker.sv */
// Checker for the unload, self-test, trigger and scan ports
`timescale 1ns/1ps
`default_nettype none
module dus_checker
   import dus_pkg::*;
#(
   parameter int SELFTEST_TRIG = 50, // Trigger delay
   parameter int SELFTEST_HOLD = 100 // Test time
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] pwdata, // Wdata
   input wire logic [31:0] prdata, // Rdata
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic q_resp, // Valid
   input wire logic [dus_pkg::ADDR_W-1:0] oldest_addr, // Base
   input wire logic [dus_pkg::ADDR_W-1:0] mem_size_sw, // Size
   input wire logic [dus_pkg::ADDR_W-1:0] mem_addr, // Addr
   input wire logic mem_rd, // Strobe
   input wire logic [dus_pkg::WORD_W-1:0] mem_rdata, // Word
   input wire logic ext_clk_pin, // Clock pin
   input wire logic ext_trig_pin, // Trigger pin
   input wire logic sample_tick, // Tick
   input wire logic event_trig, // Trigger
   input wire logic selftest_sel, // Test
   input wire logic scan_busy // Scan
);
   import dus_pkg::*;
   logic tk;
   logic arm;
   logic eq;
   logic [1:0] cc;
   logic [5:0] cnt;
   logic [19:0] exp_a;
   logic [19:0] la;
   int sc;
   int bc;
   int sl;
   function automatic logic [19:0] wrap(input logic [26:0] v);
      return (mem_size_sw == 20'h0) ? v[19:0] : 20'(v % 27'(mem_size_sw));
   endfunction
   assign tk = psel && penable && !pready && pwrite;
   assign cnt = 6'h04 << cc;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm <= 1'b0;
         eq <= 1'b0;
         cc <= 2'h3;
         exp_a <= 20'h0;
         la <= 20'h0;
         sc <= 0;
         bc <= 0;
         sl <= 0;
      end else begin
         sc <= selftest_sel ? sc + 1 : 0;
         bc <= scan_busy ? bc + 1 : 0;
         if (scan_busy && bc == 0) begin
            sl <= (int'(cnt) + 1) * SCAN_STEP_CYC;
         end
         if (mem_rd) begin
            la <= mem_addr;
         end
         if (tk && paddr == ADDR_CONFIG) begin
            cc <= pwdata[1:0];
         end
         if (tk && paddr == ADDR_CMD && (pwdata[3] || pwdata[2])) begin
            arm <= !pwdata[3];
         end
         if (tk && paddr == ADDR_UNLOAD) begin
            exp_a <= wrap(27'(oldest_addr) + 27'(cnt) * 27'(pwdata[27:8]) + 27'(pwdata[4:0]));
            eq <= 6'(pwdata[4:0]) < cnt;
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====
   a_unload_fetch: assert property (tk && paddr == ADDR_UNLOAD
      |=> ##[0:3] (mem_rd && mem_addr == exp_a)) else $error("unload fetch address wrong");
   a_read_step: assert property (psel && penable && !pready && !pwrite && paddr == ADDR_DATA
      |=> ##[0:38] (mem_rd && mem_addr == wrap(27'(la) + 27'(cnt)))) else $error("reload step wrong");
   a_q_valid: assert property (tk && paddr == ADDR_UNLOAD
      |=> ##[0:3] (q_resp == eq)) else $error("q response wrong");
   a_selftest_len: assert property ($fell(selftest_sel)
      |-> sc >= SELFTEST_HOLD - 2 && sc <= SELFTEST_HOLD + 2) else $error("self test length");
   a_selftest_trig: assert property (selftest_sel && arm && sc == SELFTEST_TRIG - 3
      |-> ##[0:6] event_trig) else $error("self test trigger missing");
   a_cmd_trig: assert property (tk && paddr == ADDR_CMD && pwdata[0] && arm
      |-> ##[1:3] event_trig) else $error("command trigger missing");
   a_pin_trig: assert property ($rose(ext_trig_pin) && arm
      |-> ##[1:5] event_trig) else $error("panel trigger missing");
   a_scan_len: assert property ($fell(scan_busy)
      |-> bc <= sl && bc >= sl - 2) else $error("scan length");
   c_fetch: cover property (mem_rd);
   c_selftest: cover property ($fell(selftest_sel));
   c_scan: cover property ($fell(scan_busy));
endmodule // dus_checker
`default_nettype wire

/* dv/dus_mem_model.sv */
// External memory model answering unload fetches
`timescale 1ns/1ps
`default_nettype none
module dus_mem_model (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic [19:0] mem_addr, // Address
   input wire logic mem_rd, // Read strobe
   output logic [15:0] mem_rdata // Word
);
   logic [19:0] a;
   logic [3:0] c;
   logic [15:0] w;
   assign w = a[15:0] ^ {a[19:16], 12'h3c5};
   // Word valid only for a short hold after the strobe
   assign mem_rdata = (c != 4'h0) ? w : ~w;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a <= 20'h0;
         c <= 4'h0;
      end else if (mem_rd) begin
         a <= mem_addr;
         c <= 4'h1;
      end else if (c != 4'h0) begin
         c <= (c == 4'h8) ? 4'h0 : c + 4'h1;
      end
   end
endmodule // dus_mem_model
`default_nettype wire

/* dv/dus_top_tb.sv */
// Testbench for the unload and sequencing block
`timescale 1ns/1ps
`default_nettype none
module dus_top_tb;
   import dus_pkg::*;
   localparam int ST_TRIG = 50;
   localparam int ST_HOLD = 100;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic ext_clk_pin = 0, ext_trig_pin = 0, er;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, q_resp, mem_rd, sample_tick, event_trig, selftest_sel, scan_busy;
   logic [19:0] oldest_addr = 20'h0, mem_size_sw = 20'h0, mem_addr;
   logic [15:0] mem_rdata;
   int error_cnt = 0, n_compared = 0, trig_cnt = 0, tick_cnt = 0, busy_cyc = 0;
   always #25 pclk = ~pclk;
   always @(posedge pclk) begin
      trig_cnt <= trig_cnt + int'(event_trig === 1'b1);
      tick_cnt <= tick_cnt + int'(sample_tick === 1'b1);
      busy_cyc <= busy_cyc + int'(scan_busy === 1'b1);
   end
   dus_top #(.SELFTEST_TRIG(ST_TRIG), .SELFTEST_HOLD(ST_HOLD)) dut_u (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .q_resp(q_resp),
      .oldest_addr(oldest_addr), .mem_size_sw(mem_size_sw), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_rdata(mem_rdata), .ext_clk_pin(ext_clk_pin),
      .ext_trig_pin(ext_trig_pin), .sample_tick(sample_tick), .event_trig(event_trig),
      .selftest_sel(selftest_sel), .scan_busy(scan_busy));
   dus_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_addr(mem_addr),
      .mem_rd(mem_rd), .mem_rdata(mem_rdata));
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      rd = prdata;
      er = pslverr;
      chk(n < 64, "no ready");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [19:0] wrap(input logic [26:0] v, input logic [19:0] s);
      return (s == 20'h0) ? v[19:0] : 20'(v % 27'(s));
   endfunction
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic pulse_clk(input int k);
      repeat (2 * k) begin
         ext_clk_pin <= ~ext_clk_pin;
         repeat (5) @(posedge pclk);
      end
   endtask
   initial begin
      #(100_000 * 50);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      int c, ch, s, n;
      logic [19:0] a;
      void'($urandom(49));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, ADDR_CONFIG, 32'h0);
      chk(rd === 32'h3, "config reset");
      apb(1'b0, 12'h01c, 32'h0);
      chk(er === 1'b1, "unmapped access");
      $display("test reset done");
      // =====
      for (int i = 0; i < 8; i++) begin
         c = (i < 4) ? i : int'($urandom % 4);
         ch = (i == 1) ? 8 : (i == 2) ? 15 : int'($urandom % 32);
         s = $urandom % 3000;
         mem_size_sw <= (i == 0) ? 20'h0 : 20'($urandom_range(4096, 64));
         oldest_addr <= 20'($urandom % 64);
         apb(1'b1, ADDR_CONFIG, 32'(c));
         apb(1'b1, ADDR_UNLOAD, (32'(s) << 8) | 32'(ch));
         a = wrap(27'(oldest_addr) + 27'(4 << c) * 27'(s) + 27'(ch), mem_size_sw);
         chk(q_resp === (ch < (4 << c)), "q response");
         for (int k = 0; k < 3 && ch < (4 << c); k++) begin
            n = 0;
            do begin
               apb(1'b0, ADDR_STATUS, 32'h0);
               n++;
            end while (rd[4] !== 1'b1 && n < 20);
            apb(1'b0, ADDR_DATA, 32'h0);
            chk(rd === {16'h0, a[15:0] ^ {a[19:16], 12'h3c5}}, "buffer word");
            a = wrap(27'(a) + 27'(4 << c), mem_size_sw);
         end
      end
      $display("test unload done");
      // =====
      apb(1'b1, ADDR_CMD, 32'h4);
      c = trig_cnt;
      apb(1'b1, ADDR_CMD, 32'h1);
      repeat (4) @(posedge pclk);
      chk(trig_cnt == c + 1, "command trigger");
      apb(1'b1, ADDR_CMD, 32'h4);
      ext_trig_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_trig_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(trig_cnt == c + 2, "panel trigger");
      apb(1'b1, ADDR_CMD, 32'h8);
      apb(1'b1, ADDR_CMD, 32'h1);
      repeat (4) @(posedge pclk);
      chk(trig_cnt == c + 2, "trigger while idle");
      apb(1'b1, ADDR_CONFIG, 32'h21);
      apb(1'b1, ADDR_CMD, 32'h4);
      c = trig_cnt;
      apb(1'b1, ADDR_CMD, 32'h2);
      chk(selftest_sel === 1'b1, "self test on");
      repeat (ST_TRIG + 4) @(posedge pclk);
      chk(trig_cnt == c + 1, "self test trigger");
      repeat (ST_HOLD - ST_TRIG) @(posedge pclk);
      chk(selftest_sel === 1'b0, "self test off");
      apb(1'b0, ADDR_CONFIG, 32'h0);
      chk(rd === 32'h21, "config kept");
      apb(1'b1, ADDR_CMD, 32'h8);
      $display("test self test done");
      // =====
      for (int r = 0; r < 10; r++) begin
         apb(1'b1, ADDR_CONFIG, 32'(r) << 4);
         apb(1'b0, ADDR_CONFIG, 32'h0);
         chk(rd[7:4] === 4'((r < 9) ? r : 8), "rate code");
         for (int k = 0; k < 2 && r < 3; k++) begin
            c = tick_cnt;
            s = 0;
            while (tick_cnt == c && s < 9000) begin
               @(posedge pclk);
               s++;
            end
         end
         chk(r > 2 || s == CLK_HZ / (40000 >> r), "tick period");
      end
      apb(1'b1, ADDR_CONFIG, 32'h4);
      c = tick_cnt;
      pulse_clk(4);
      chk(tick_cnt == c + 4, "external ticks");
      apb(1'b1, ADDR_CMD, 32'h4);
      c = busy_cyc;
      pulse_clk(1);
      repeat (600) @(posedge pclk);
      chk(busy_cyc == c + 500, "scan length");
      $display("test clock done");
      tally_and_finish();
   end
endmodule // dus_top_tb
bind dus_top dus_checker #(.SELFTEST_TRIG(SELFTEST_TRIG), .SELFTEST_HOLD(SELFTEST_HOLD)) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .q_resp(q_resp), .oldest_addr(oldest_addr), .mem_size_sw(mem_size_sw),
   .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .ext_clk_pin(ext_clk_pin),
   .ext_trig_pin(ext_trig_pin), .sample_tick(sample_tick), .event_trig(event_trig),
   .selftest_sel(selftest_sel), .scan_busy(scan_busy));
`default_nettype wire
